// ---- sqb_stats.sv ----
// module: service, queue and bundle policer statistics counters
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - per service type byte or frame mode
// - service index: base plus offset, or VLAN
// - service mask bits 0..2 green/yellow/red
// - service mask bits 3..5 unicast/multicast/flood
// - one service mask per type, shared
// - low three types 40-bit, upper 32-bit
// - 40-bit read as low word, high byte
// - low-word read latches high part to shadow
// - one bit selects precedence or policer colour
// - map translates precedence into service colour
// - service reset clears every service counter
// - queue index is port times 8 plus priority
// - queue mask: passed or discarded by policer
// - queue mask and mode shared over queues
// - bundle mask and mode shared per position
// - bundle mask: green, yellow, red
// - triggered counter adds length or one
module sqb_stats
  import sqb_pkg::*;
#(
  parameter int SVC_N  = 64, // service entries
  parameter int PORT_N = 8,  // ingress ports
  parameter int BDL_N  = 16  // bundle policers
) (
  input  wire logic                      I_CLOCK,       // 25 MHz core clock
  input  wire logic                      I_RSTN,        // synchronous reset, low
  input  wire logic [sqb_pkg::ADDR_W-1:0] I_ADDR,       // register byte address
  input  wire logic [sqb_pkg::DATA_W-1:0] I_WDATA,      // write data
  input  wire logic                      I_WR,          // write strobe
  input  wire logic                      I_RD,          // read strobe
  output logic      [sqb_pkg::DATA_W-1:0] O_RDATA,      // read data, cycle after strobe
  input  wire logic                      I_FRM_VALID,   // one frame event this cycle
  input  wire logic [13:0]               I_FRM_LEN,     // frame length in bytes
  input  wire logic [1:0]                I_FRM_PREC,    // drop_precedence
  input  wire logic [2:0]                I_POL_COLOUR,  // policer colour one-hot g/y/r
  input  wire logic [2:0]                I_FRM_FWD,     // one-hot ucast/mcast/flood
  input  wire logic [11:0]               I_SVC_BASE,    // service_base_address
  input  wire logic [2:0]                I_COS_OFS,     // class_of_service_offset
  input  wire logic [11:0]               I_VID,         // frame VLAN ID
  input  wire logic [2:0]                I_PORT,        // ingress port
  input  wire logic [2:0]                I_IPRIO,       // internal priority
  input  wire logic [1:0]                I_QUE_EV,      // queue policer pass/discard
  input  wire logic                      I_BDL_HIT,     // frame hit a bundle policer
  input  wire logic [3:0]                I_BDL_IDX,     // bundle policer index
  input  wire logic [2:0]                I_BDL_COLOUR,  // bundle colour one-hot g/y/r
  output logic                           O_SVC_CLEARING // service clear in progress
);
  localparam int QUE_N = PORT_N * QUE_PER_PORT;
  localparam int SW    = $clog2(SVC_N);
  localparam int QW    = $clog2(QUE_N);
  localparam int BW    = $clog2(BDL_N);

  // ---------------------------------------------------------------
  // counter storage
  // ---------------------------------------------------------------
  logic [39:0] svc_cnt [SVC_N][SVC_TYPES];
  logic [39:0] que_cnt [QUE_N][2];
  logic [39:0] bdl_cnt [BDL_N][2];

  // ---------------------------------------------------------------
  // configuration and control state of the block as one struct
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [5:0]        svc_byte;
    logic [5:0][5:0]   svc_mask;
    logic              vlan_idx;
    logic              colour_sel;
    logic [7:0]        cmap;
    logic [1:0]        que_byte;
    logic [1:0][1:0]   que_mask;
    logic [1:0]        bdl_byte;
    logic [1:0][2:0]   bdl_mask;
    logic              clearing;
    logic [SW-1:0]     clr_idx;
    logic [7:0]        shadow;
    logic [7:0]        wr_high;
    logic [31:0]       rdata;
  } sqb_state_s;

  sqb_state_s st;
  sqb_state_s next_st;

  // ---------------------------------------------------------------
  // frame classification
  // ---------------------------------------------------------------
  logic [1:0]    prec_colour;
  logic [2:0]    svc_colour;
  logic [5:0]    svc_flags;
  logic [11:0]   svc_idx_full;
  logic [SW-1:0] svc_idx;
  logic [QW-1:0] que_idx;
  logic [BW-1:0] bdl_idx;

  // colour and index selection for this frame
  always_comb begin
    prec_colour  = st.cmap[{I_FRM_PREC, 1'b0} +: 2];
    svc_colour   = 3'h0;
    if (st.colour_sel) begin
      svc_colour = I_POL_COLOUR;
    end else if (prec_colour < 2'h3) begin
      svc_colour[prec_colour] = 1'b1;
    end
    svc_flags    = {I_FRM_FWD, svc_colour};
    svc_idx_full = st.vlan_idx ? I_VID : 12'(I_SVC_BASE + 12'(I_COS_OFS));
    svc_idx      = svc_idx_full[SW-1:0];
    que_idx      = QW'({I_PORT, I_IPRIO}); // port*8+prio
    bdl_idx      = I_BDL_IDX[BW-1:0];
  end

  // add length or one
  function automatic logic [39:0] step(input logic byte_mode, input logic [13:0] len);
    step = byte_mode ? 40'(len) : 40'h1;
  endfunction : step

  // ---------------------------------------------------------------
  // register decode
  // ---------------------------------------------------------------
  logic [1:0]    win;
  logic [SW-1:0] a_ent;
  logic [2:0]    a_slot;
  logic          a_high;
  logic [39:0]   sel_cnt;
  logic          sel_ok;

  // counter window addressing and read selection
  always_comb begin
    win     = I_ADDR[11:10];
    a_ent   = SW'(I_ADDR[9:6]);
    a_slot  = I_ADDR[5:3];
    a_high  = I_ADDR[2];
    sel_cnt = 40'h0;
    sel_ok  = 1'b0;
    case (win)
      2'h1: begin
        sel_ok  = (a_slot < 3'h6) && (32'(a_ent) < SVC_N);
        if (sel_ok) begin
          sel_cnt = svc_cnt[a_ent][a_slot];
        end
      end
      2'h2: begin
        sel_ok  = (a_slot < 3'h2) && (32'(a_ent) < QUE_N);
        if (sel_ok) begin
          sel_cnt = que_cnt[QW'(a_ent)][a_slot[0]];
        end
      end
      2'h3: begin
        sel_ok  = (a_slot < 3'h2) && (32'(a_ent) < BDL_N);
        if (sel_ok) begin
          sel_cnt = bdl_cnt[BW'(a_ent)][a_slot[0]];
        end
      end
      default: begin
        sel_ok  = 1'b0;
      end
    endcase
  end

  // high word exists for every counter except the narrow service types
  logic has_high;
  assign has_high = sel_ok && !(win == 2'h1 && a_slot >= 3'h3);

  // ---------------------------------------------------------------
  // next state: configuration, shadow, read data
  // ---------------------------------------------------------------
  always_comb begin
    next_st = st;
    if (st.clearing) begin
      next_st.clr_idx = SW'(st.clr_idx + 1'b1);
      if (32'(st.clr_idx) == SVC_N - 1) begin
        next_st.clearing = 1'b0;
      end
    end
    if (I_WR) begin
      case (I_ADDR)
        OFS_SVC_BYTE: next_st.svc_byte = I_WDATA[5:0];
        OFS_SVC_RESET: begin
          if (I_WDATA[0]) begin
            next_st.clearing = 1'b1;
            next_st.clr_idx  = '0;
          end
        end
        OFS_SVC_CTRL: begin
          next_st.vlan_idx   = I_WDATA[0];
          next_st.colour_sel = I_WDATA[1];
          next_st.cmap       = I_WDATA[15:8];
        end
        OFS_QUE_CFG: begin
          next_st.que_byte = I_WDATA[1:0];
          next_st.que_mask = I_WDATA[5:2];
        end
        OFS_BDL_CFG: begin
          next_st.bdl_byte = I_WDATA[1:0];
          next_st.bdl_mask = I_WDATA[7:2];
        end
        default: begin
          if (I_ADDR >= OFS_SVC_MASK0 && I_ADDR < OFS_SVC_RESET) begin
            next_st.svc_mask[3'(I_ADDR[4:2] - 3'h1)] = I_WDATA[5:0];
          end
          if (win != 2'h0 && a_high) begin
            next_st.wr_high = I_WDATA[7:0]; // held until the low word lands
          end
        end
      endcase
    end
    next_st.rdata = 32'h0;
    if (I_RD) begin
      case (I_ADDR)
        OFS_SVC_BYTE:  next_st.rdata = 32'(st.svc_byte);
        OFS_SVC_CTRL:  next_st.rdata = {16'h0, st.cmap, 6'h0, st.colour_sel, st.vlan_idx};
        OFS_QUE_CFG:   next_st.rdata = {26'h0, st.que_mask, st.que_byte};
        OFS_BDL_CFG:   next_st.rdata = {24'h0, st.bdl_mask, st.bdl_byte};
        OFS_STATUS:    next_st.rdata = {31'h0, st.clearing};
        default: begin
          if (I_ADDR >= OFS_SVC_MASK0 && I_ADDR < OFS_SVC_RESET) begin
            next_st.rdata = 32'(st.svc_mask[3'(I_ADDR[4:2] - 3'h1)]);
          end else if (win != 2'h0 && !a_high) begin
            next_st.rdata = sel_cnt[31:0];
            if (has_high) begin
              next_st.shadow = sel_cnt[39:32];
            end
          end else if (win != 2'h0 && has_high) begin
            next_st.rdata = 32'(st.shadow);
          end
        end
      endcase
    end
    if (!I_RSTN) begin
      next_st            = '0;
      next_st.svc_byte   = SVC_BYTE_RST;
      next_st.cmap       = CMAP_RST;
      next_st.svc_mask   = {SVC_TYPES{SVC_MASK_RST}};
    end
  end

  // register the state
  always_ff @(posedge I_CLOCK) begin
    st <= next_st;
  end

  // ---------------------------------------------------------------
  // counter update: software write, clear, or frame count
  // ---------------------------------------------------------------
  logic cpu_lo_wr;
  assign cpu_lo_wr = I_WR && sel_ok && !a_high;

  // service counters; a wide counter takes the held high byte
  always_ff @(posedge I_CLOCK) begin
    for (int t = 0; t < SVC_TYPES; t++) begin
      if (st.clearing) begin
        svc_cnt[st.clr_idx][t] <= 40'h0;
      end else if (cpu_lo_wr && win == 2'h1 && a_slot == 3'(t)) begin
        svc_cnt[a_ent][t] <= (t < SVC_WIDE) ? {st.wr_high, I_WDATA} : {8'h0, I_WDATA};
      end else if (I_FRM_VALID && (st.svc_mask[t] & svc_flags) != 6'h0) begin
        if (t < SVC_WIDE) begin
          svc_cnt[svc_idx][t] <= svc_cnt[svc_idx][t] + step(st.svc_byte[t], I_FRM_LEN);
        end else begin
          svc_cnt[svc_idx][t] <= {8'h0, 32'(svc_cnt[svc_idx][t][31:0]
                                 + 32'(step(st.svc_byte[t], I_FRM_LEN)))};
        end
      end
    end
  end

  // queue and bundle counters, two per entry
  always_ff @(posedge I_CLOCK) begin
    for (int c = 0; c < 2; c++) begin
      if (cpu_lo_wr && win == 2'h2 && a_slot[0] == 1'(c)) begin
        que_cnt[QW'(a_ent)][c] <= {st.wr_high, I_WDATA};
      end else if (I_FRM_VALID && (st.que_mask[c] & I_QUE_EV) != 2'h0) begin
        que_cnt[que_idx][c] <= que_cnt[que_idx][c] + step(st.que_byte[c], I_FRM_LEN);
      end
      if (cpu_lo_wr && win == 2'h3 && a_slot[0] == 1'(c)) begin
        bdl_cnt[BW'(a_ent)][c] <= {st.wr_high, I_WDATA};
      end else if (I_FRM_VALID && I_BDL_HIT
                   && (st.bdl_mask[c] & I_BDL_COLOUR) != 3'h0) begin
        bdl_cnt[bdl_idx][c] <= bdl_cnt[bdl_idx][c] + step(st.bdl_byte[c], I_FRM_LEN);
      end
    end
  end

  // outputs straight from the state register
  assign O_RDATA        = st.rdata;
  assign O_SVC_CLEARING = st.clearing;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge I_CLOCK); endclocking
  default disable iff (!I_RSTN);

  shadow_on_low_a: assert property ((I_RD && win != 2'h0 && !a_high && has_high)
    |=> st.shadow == $past(sel_cnt[39:32]))
    else $error("shadow not loaded on low-word read");
  high_from_shadow_a: assert property ((I_RD && win != 2'h0 && a_high && has_high)
    |=> O_RDATA == 32'(st.shadow))
    else $error("high word does not show shadow");
  clear_done_a: assert property ($rose(st.clearing) |-> ##[1:300] !st.clearing)
    else $error("service clear never ends");
  byte_cfg_a: assert property ((I_WR && I_ADDR == OFS_SVC_BYTE)
    |=> st.svc_byte == $past(I_WDATA[5:0]))
    else $error("service byte mode not stored");
  colour_sel_a: assert property (st.colour_sel |-> svc_flags[2:0] == I_POL_COLOUR)
    else $error("policer colour not used");
  vlan_index_a: assert property (st.vlan_idx |-> svc_idx == I_VID[SW-1:0])
    else $error("vlan index not used");
  queue_index_a: assert property (que_idx == QW'(I_PORT * 8 + I_IPRIO))
    else $error("queue index wrong");
  narrow_high_a: assert property ((win == 2'h1 && a_slot >= 3'h3) |-> !has_high)
    else $error("narrow service counter has high word");

  // ---------------------------------------------------------------
  // checks: register bus and shadow
  // ---------------------------------------------------------------
  // read data stands one cycle only, idle bus reads as zero
  rdata_idle_a: assert property (!I_RD |=> O_RDATA == 32'h0)
    else $error("read data not zero without read");
  // shadow only moves on a low-word read of a wide counter
  shadow_hold_a: assert property (!(I_RD && win != 2'h0 && !a_high && has_high)
    |=> $stable(st.shadow))
    else $error("shadow changed without low-word read");
  // a high-word write is held until the low word commits
  high_held_a: assert property ((I_WR && win != 2'h0 && a_high)
    |=> st.wr_high == $past(I_WDATA[7:0]))
    else $error("high word not held");
  // low-word write of a wide counter commits the held high byte with it
  wide_commit_a: assert property ((I_WR && !st.clearing && win == 2'h1 && a_slot == 3'h0
    && !a_high && sel_ok)
    |=> svc_cnt[$past(a_ent)][0] == {$past(st.wr_high), $past(I_WDATA)})
    else $error("wide counter write lost its high byte");
  // status register mirrors the clear flag
  status_read_a: assert property ((I_RD && I_ADDR == OFS_STATUS)
    |=> O_RDATA == {31'h0, $past(st.clearing)})
    else $error("status read wrong");

  // ---------------------------------------------------------------
  // checks: configuration and clear
  // ---------------------------------------------------------------
  // colour map is stored as written
  cmap_store_a: assert property ((I_WR && I_ADDR == OFS_SVC_CTRL)
    |=> st.cmap == $past(I_WDATA[15:8]))
    else $error("colour map not stored");
  // a precedence mapped to no colour raises no colour flag
  no_colour_a: assert property ((!st.colour_sel && prec_colour == 2'h3)
    |-> svc_flags[2:0] == 3'h0)
    else $error("uncoloured precedence counted");
  // queue mode and masks are one shared setting
  que_cfg_a: assert property ((I_WR && I_ADDR == OFS_QUE_CFG)
    |=> {st.que_mask, st.que_byte} == $past(I_WDATA[5:0]))
    else $error("queue setting not stored");
  // bundle mode and masks are one shared setting
  bdl_cfg_a: assert property ((I_WR && I_ADDR == OFS_BDL_CFG)
    |=> {st.bdl_mask, st.bdl_byte} == $past(I_WDATA[7:0]))
    else $error("bundle setting not stored");
  // writing the reset bit starts a clear from entry zero
  clear_start_a: assert property ((I_WR && I_ADDR == OFS_SVC_RESET && I_WDATA[0])
    |=> st.clearing && st.clr_idx == '0)
    else $error("service clear not started");
  // a running clear walks one entry per cycle
  clear_step_a: assert property ((st.clearing && !I_WR)
    |=> st.clr_idx == SW'($past(st.clr_idx) + 1'b1))
    else $error("service clear skipped an entry");
  // without vlan indexing the base plus offset is used
  base_index_a: assert property (!st.vlan_idx
    |-> svc_idx == SW'(I_SVC_BASE + 12'(I_COS_OFS)))
    else $error("base index not used");
endmodule : sqb_stats
`default_nettype wire

// ---- sqb_pkg.sv ----
// package: constants and register map of the service, queue and bundle statistics block
package sqb_pkg;
  // ---------------------------------------------------------------
  // bus widths
  // ---------------------------------------------------------------
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  // ---------------------------------------------------------------
  // register byte offsets (each register one aligned word)
  // ---------------------------------------------------------------
  localparam logic [11:0] OFS_SVC_BYTE    = 12'h000; // byte_mode_select, 6 bits
  localparam logic [11:0] OFS_SVC_MASK0   = 12'h004; // service masks 0..5 at +4*n
  localparam logic [11:0] OFS_SVC_RESET   = 12'h01C; // write 1: clear service counters
  localparam logic [11:0] OFS_SVC_CTRL    = 12'h020; // vlan idx, colour sel, colour map
  localparam logic [11:0] OFS_QUE_CFG     = 12'h024; // byte[1:0], mask0[3:2], mask1[5:4]
  localparam logic [11:0] OFS_BDL_CFG     = 12'h028; // byte[1:0], mask0[4:2], mask1[7:5]
  localparam logic [11:0] OFS_STATUS      = 12'h02C; // read: counters-in-clear flag
  localparam logic [11:0] OFS_SVC_CNT     = 12'h400; // service counters window
  localparam logic [11:0] OFS_QUE_CNT     = 12'h800; // queue counters window
  localparam logic [11:0] OFS_BDL_CNT     = 12'hC00; // bundle counters window
  // counter window byte address: [9:6] entry, [5:3] counter slot, [2] high word
  // (only the first 16 entries of a family are reachable from software)
  // ---------------------------------------------------------------
  // reset values and field positions
  // ---------------------------------------------------------------
  localparam logic [5:0] SVC_BYTE_RST   = 6'h07;   // low three types count bytes
  localparam logic [5:0] SVC_MASK_RST   = 6'h00;
  localparam logic [7:0] CMAP_RST       = 8'hE4;   // precedence n -> colour n
  localparam int         EV_GREEN       = 0;
  localparam int         EV_YELLOW      = 1;
  localparam int         EV_RED         = 2;
  localparam int         EV_UCAST       = 3;
  localparam int         EV_MCAST       = 4;
  localparam int         EV_FLOOD       = 5;
  localparam int         SVC_TYPES      = 6;
  localparam int         SVC_WIDE       = 3;       // types with 40-bit counters
  localparam int         QUE_PER_PORT   = 8;
endpackage : sqb_pkg

// ---- sqb_frame_src.sv ----
// frame event source standing in for the analyzer pipeline
`timescale 1ns/1ps
`default_nettype none
module sqb_frame_src (
  input  wire logic        i_clock, // core clock
  output var  logic        o_valid, // frame event pulse
  output var  logic [13:0] o_len,   // byte length
  output var  logic [1:0]  o_prec,  // drop_precedence
  output var  logic [2:0]  o_fwd,   // ucast/mcast/flood one-hot
  output var  logic [2:0]  o_pcol,  // policer colour one-hot
  output var  logic [11:0] o_base,  // service_base_address
  output var  logic [2:0]  o_cos,   // class_of_service_offset
  output var  logic [11:0] o_vid,   // vlan id
  output var  logic [2:0]  o_port,  // ingress port
  output var  logic [2:0]  o_prio,  // internal priority
  output var  logic [1:0]  o_qev,   // queue pass/discard
  output var  logic        o_bhit,  // bundle policer hit
  output var  logic [3:0]  o_bidx,  // bundle index
  output var  logic [2:0]  o_bcol   // bundle colour one-hot
);
  // ---------------------------------------------------------------
  // one frame per call, payload scrambled between frames
  // ---------------------------------------------------------------
  initial begin
    o_valid = 1'b0;
    {o_len, o_prec, o_fwd, o_pcol, o_base, o_cos, o_vid, o_port, o_prio, o_qev, o_bhit,
     o_bidx, o_bcol} = '0;
  end
  task automatic send(input logic [13:0] len, input logic [1:0] prec = 0,
                      input logic [2:0] fwd = 1, pcol = 1, input logic [11:0] base = 0,
                      input logic [2:0] cos = 0, input logic [11:0] vid = 0,
                      input logic [2:0] port = 0, prio = 0, input logic [1:0] qev = 0,
                      input logic bhit = 0, input logic [3:0] bidx = 0,
                      input logic [2:0] bcol = 1);
    @(posedge i_clock);
    o_valid <= 1'b1;
    {o_len, o_prec, o_fwd, o_pcol, o_base, o_cos, o_vid, o_port, o_prio, o_qev, o_bhit,
     o_bidx, o_bcol} <= {len, prec, fwd, pcol, base, cos, vid, port, prio, qev, bhit, bidx, bcol};
    @(posedge i_clock);
    o_valid <= 1'b0;
    // stale fields must not look like a live frame
    {o_len, o_prec, o_fwd, o_pcol, o_base, o_cos, o_vid, o_port, o_prio, o_qev, o_bhit,
     o_bidx, o_bcol} <= ~{len, prec, fwd, pcol, base, cos, vid, port, prio, qev, bhit, bidx, bcol};
  endtask : send
endmodule : sqb_frame_src
`default_nettype wire

// ---- sqb_stats_tb.sv ----
// testbench for the service, queue and bundle statistics block
`timescale 1ns/1ps
`default_nettype none
module sqb_stats_tb;
  import sqb_pkg::*;
  logic I_CLOCK, I_RSTN, I_WR, I_RD, I_FRM_VALID, I_BDL_HIT, O_SVC_CLEARING;
  logic [11:0] I_ADDR, I_SVC_BASE, I_VID;
  logic [31:0] I_WDATA, O_RDATA;
  logic [13:0] I_FRM_LEN;
  logic [1:0]  I_FRM_PREC, I_QUE_EV;
  logic [2:0]  I_POL_COLOUR, I_FRM_FWD, I_COS_OFS, I_PORT, I_IPRIO, I_BDL_COLOUR;
  logic [3:0]  I_BDL_IDX;
  int          fail_count = 0;
  int          n_compared = 0;
  sqb_stats i_sqb_stats (.I_CLOCK(I_CLOCK), .I_RSTN(I_RSTN), .I_ADDR(I_ADDR), .I_WDATA(I_WDATA),
    .I_WR(I_WR), .I_RD(I_RD), .O_RDATA(O_RDATA), .I_FRM_VALID(I_FRM_VALID), .I_FRM_LEN(I_FRM_LEN),
    .I_FRM_PREC(I_FRM_PREC), .I_POL_COLOUR(I_POL_COLOUR), .I_FRM_FWD(I_FRM_FWD),
    .I_SVC_BASE(I_SVC_BASE), .I_COS_OFS(I_COS_OFS), .I_VID(I_VID), .I_PORT(I_PORT),
    .I_IPRIO(I_IPRIO), .I_QUE_EV(I_QUE_EV), .I_BDL_HIT(I_BDL_HIT), .I_BDL_IDX(I_BDL_IDX),
    .I_BDL_COLOUR(I_BDL_COLOUR), .O_SVC_CLEARING(O_SVC_CLEARING));
  sqb_frame_src i_sqb_frame_src (.i_clock(I_CLOCK), .o_valid(I_FRM_VALID), .o_len(I_FRM_LEN),
    .o_prec(I_FRM_PREC), .o_fwd(I_FRM_FWD), .o_pcol(I_POL_COLOUR), .o_base(I_SVC_BASE),
    .o_cos(I_COS_OFS), .o_vid(I_VID), .o_port(I_PORT), .o_prio(I_IPRIO), .o_qev(I_QUE_EV),
    .o_bhit(I_BDL_HIT), .o_bidx(I_BDL_IDX), .o_bcol(I_BDL_COLOUR));
  // ---------------------------------------------------------------
  // bus and compare helpers
  // ---------------------------------------------------------------
  task automatic chk(input string nm, input logic [39:0] seen, exp);
    n_compared++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge I_CLOCK);
    I_WR <= 1'b1; I_ADDR <= a; I_WDATA <= d;
    @(posedge I_CLOCK);
    I_WR <= 1'b0;
  endtask : wr
  task automatic rd(input logic [11:0] a, output logic [31:0] d);
    @(posedge I_CLOCK);
    I_RD <= 1'b1; I_ADDR <= a;
    @(posedge I_CLOCK);
    I_RD <= 1'b0;
    #1 d = O_RDATA;
  endtask : rd
  function automatic logic [11:0] ca(input logic [11:0] b, input int e, s, h);
    return b + 12'(e * 64 + s * 8 + h * 4);
  endfunction : ca
  // low word first, then high word from the shadow
  task automatic r40(input logic [11:0] a, output logic [39:0] v);
    logic [31:0] l, h;
    rd(a, l); rd(a + 12'h004, h);
    v = {h[7:0], l};
  endtask : r40
  task automatic w40(input logic [11:0] a, input logic [39:0] v);
    wr(a + 12'h004, {24'h000000, v[39:32]}); wr(a, v[31:0]);
  endtask : w40
  // all six service slots of one entry; narrow ones have no high word
  task automatic ent(input int e, input logic [39:0] x [6]);
    logic [39:0] v;
    logic [31:0] h;
    for (int s = 0; s < 6; s++) begin
      if (s < SVC_WIDE) r40(ca(OFS_SVC_CNT, e, s, 0), v);
      else rd(ca(OFS_SVC_CNT, e, s, 0), v[31:0]);
      if (s >= SVC_WIDE) v[39:32] = 8'h00;
      chk("service count", v, x[s]);
      if (s >= SVC_WIDE) rd(ca(OFS_SVC_CNT, e, s, 1), h);
      if (s >= SVC_WIDE) chk("narrow high", 40'(h), 40'h0);
    end
  endtask : ent
  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_regs;
    logic [31:0] d;
    rd(OFS_SVC_BYTE, d); chk("byte mode rst", 40'(d), 40'h07);
    rd(OFS_SVC_CTRL, d); chk("ctrl rst", 40'(d), 40'h0000E400);
    rd(12'h030, d); chk("unmapped", 40'(d), 40'h0);
  endtask : t_regs
  task automatic t_clear;
    int k;
    logic [31:0] d;
    wr(OFS_SVC_RESET, 32'h1);
    @(posedge I_CLOCK);
    #1 chk("clearing", 40'(O_SVC_CLEARING), 40'h1);
    rd(OFS_STATUS, d);
    chk("status clearing", 40'(d), 40'h1);
    for (k = 0; k < 200 && O_SVC_CLEARING !== 1'b0; k++) @(posedge I_CLOCK);
    if (k == 200) begin
      fail_count++;
      $display("mismatch clear end expected 0 seen 1");
      finish_test();
    end
    rd(OFS_STATUS, d);
    chk("status idle", 40'(d), 40'h0);
  endtask : t_clear
  // reset in mid-run brings the settings back to their reset values
  task automatic t_reset;
    logic [31:0] d;
    @(posedge I_CLOCK);
    I_RSTN <= 1'b0;
    repeat (2) @(posedge I_CLOCK);
    I_RSTN <= 1'b1;
    rd(OFS_SVC_MASK0, d);
    chk("mask rst", 40'(d), 40'h0);
    rd(OFS_QUE_CFG, d);
    chk("queue cfg rst", 40'(d), 40'h0);
    rd(OFS_SVC_BYTE, d);
    chk("byte mode rst 2", 40'(d), 40'h07);
  endtask : t_reset
  task automatic t_colour;
    for (int n = 0; n < 6; n++) wr(OFS_SVC_MASK0 + 12'(4 * n), 32'(1 << (n % 3)));
    i_sqb_frame_src.send(100, 0, 1, 1, 4, 1); // green, entry 5
    i_sqb_frame_src.send(50, 1, 1, 1, 4, 1);  // yellow
    i_sqb_frame_src.send(60, 3, 1, 1, 4, 1);  // precedence without colour
    wr(OFS_SVC_CTRL, 32'h0000E402);
    i_sqb_frame_src.send(200, 0, 1, 4, 4, 1); // red from policer
    wr(OFS_SVC_CTRL, 32'h00001B00);
    i_sqb_frame_src.send(7, 3, 1, 4, 4, 1);   // remapped to green
    wr(OFS_SVC_CTRL, 32'h0000E400);
    ent(5, '{40'd107, 40'd50, 40'd200, 40'd2, 40'd1, 40'd1});
  endtask : t_colour
  task automatic t_vlan;
    logic [31:0] d;
    wr(OFS_SVC_CTRL, 32'h0000E401);
    wr(OFS_SVC_BYTE, 32'h01);
    for (int n = 0; n < 6; n++) wr(OFS_SVC_MASK0 + 12'(4 * n), 32'(8 << (n % 3)));
    i_sqb_frame_src.send(40, 0, 1, 1, 0, 0, 9);
    i_sqb_frame_src.send(30, 0, 2, 1, 0, 0, 9);
    i_sqb_frame_src.send(20, 0, 4, 1, 0, 0, 9);
    ent(9, '{40'd40, 40'd1, 40'd1, 40'd1, 40'd1, 40'd1});
    rd(ca(OFS_SVC_CNT, 0, 0, 0), d); chk("base entry idle", 40'(d), 40'h0);
    wr(OFS_SVC_CTRL, 32'h0000E400);
    wr(OFS_SVC_BYTE, 32'h07);
  endtask : t_vlan
  task automatic t_wide;
    logic [39:0] v;
    logic [31:0] l, h;
    wr(OFS_SVC_MASK0, 32'h1);
    w40(ca(OFS_SVC_CNT, 2, 0, 0), 40'h5AFFFFFFFE);
    i_sqb_frame_src.send(3, 0, 1, 1, 2, 0);
    r40(ca(OFS_SVC_CNT, 2, 0, 0), v); chk("carry", v, 40'h5B00000001);
    rd(ca(OFS_SVC_CNT, 2, 0, 0), l);
    w40(ca(OFS_SVC_CNT, 2, 0, 0), 40'h7700000000);
    rd(ca(OFS_SVC_CNT, 2, 0, 1), h); chk("shadow", 40'(h), 40'h5B);
  endtask : t_wide
  task automatic t_queue;
    logic [39:0] v;
    wr(OFS_QUE_CFG, 32'h25);
    w40(ca(OFS_QUE_CNT, 11, 0, 0), 40'h0);
    w40(ca(OFS_QUE_CNT, 11, 1, 0), 40'h0);
    i_sqb_frame_src.send(64, 0, 1, 1, 0, 0, 0, 1, 3, 2'b01);
    i_sqb_frame_src.send(64, 0, 1, 1, 0, 0, 0, 1, 3, 2'b10);
    i_sqb_frame_src.send(10, 0, 1, 1, 0, 0, 0, 1, 3, 2'b11);
    r40(ca(OFS_QUE_CNT, 11, 0, 0), v); chk("queue passed", v, 40'd74);
    r40(ca(OFS_QUE_CNT, 11, 1, 0), v); chk("queue dropped", v, 40'd2);
  endtask : t_queue
  task automatic t_bundle;
    logic [39:0] v;
    wr(OFS_BDL_CFG, 32'h86);
    w40(ca(OFS_BDL_CNT, 3, 0, 0), 40'h0);
    w40(ca(OFS_BDL_CNT, 3, 1, 0), 40'h0);
    i_sqb_frame_src.send(70, 0, 1, 1, 0, 0, 0, 0, 0, 0, 1, 3, 1);
    i_sqb_frame_src.send(30, 0, 1, 1, 0, 0, 0, 0, 0, 0, 1, 3, 4);
    i_sqb_frame_src.send(5, 0, 1, 1, 0, 0, 0, 0, 0, 0, 1, 3, 2);
    i_sqb_frame_src.send(9, 0, 1, 1, 0, 0, 0, 0, 0, 0, 0, 3, 1);
    r40(ca(OFS_BDL_CNT, 3, 0, 0), v); chk("bundle green", v, 40'd1);
    r40(ca(OFS_BDL_CNT, 3, 1, 0), v); chk("bundle red", v, 40'd30);
  endtask : t_bundle
  // ---------------------------------------------------------------
  // clock, reset, sequence and verdict
  // ---------------------------------------------------------------
  task automatic finish_test;
    if (fail_count == 0 && n_compared > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : finish_test
  initial begin
    I_CLOCK = 1'b0;
    forever #20 I_CLOCK = ~I_CLOCK;
  end
  initial begin
    I_RSTN = 1'b0; I_WR = 1'b0; I_RD = 1'b0; I_ADDR = '0; I_WDATA = '0;
    repeat (6) @(posedge I_CLOCK);
    I_RSTN <= 1'b1;
    t_regs(); t_clear(); t_colour(); t_vlan(); t_wide(); t_queue(); t_bundle(); t_reset();
    finish_test();
  end
endmodule : sqb_stats_tb
`default_nettype wire
